// ### rtl/sdram_device.sv
// four-bank sdram device core: commands, banks, bursts and array
//
// Contract
// - four banks of 4,096 rows by 256 columns, 16-bit words
// - activation opens the row on address in the selected bank
// - read or write takes the start column from the low eight address bits
// - address bit ten with read or write selects auto precharge
// - auto precharge closes the row after the burst's last beat
// - precharge with bit ten high closes all banks, else the selected one
// - mode load with all banks closed stores the address inputs as the configuration
// - burst length 1, 2, 4, 8 or full page, terminable
// - burst column order sequential or interleaved
// - read data appear two or three cycles after the command
// - all inputs sampled and outputs launched on the rising clock edge
// - later burst columns generated internally from length and order
// - a new read or write may replace the burst on any cycle
// - burst stop, or precharge of the burst's bank or of all banks, ends a burst early
// - optional mode: burst reads but single-word writes
// - two byte masks govern the lower and upper data bytes
// - one bank may precharge while another is accessed
// - auto refresh and power-down through commands and clock enable
// - commands other than precharge-all, burst stop, mode load and refresh act only on the selected bank
// - mask high drops write bytes and floats read bytes
// - chip select high ignores commands, bursts in flight continue
// - clock enable low makes the edge invalid, state frozen
`timescale 1ns/10ps
module sdram_device
(
  input  wire logic                           sys_clk,
  input  wire logic                           reset_n,
  input  wire logic                           clk_en,
  input  wire logic                           chip_select_n,
  input  wire logic                           row_strobe_n,
  input  wire logic                           col_strobe_n,
  input  wire logic                           write_enable_n,
  input  wire logic                           bank_select_bit0,
  input  wire logic                           bank_select_bit1,
  input  wire logic [sdram_pkg::ADDR_BITS-1:0] addr,
  input  wire logic                           lower_byte_mask,
  input  wire logic                           upper_byte_mask,
  input  wire logic [sdram_pkg::DATA_BITS-1:0] dq_in,
  output logic      [sdram_pkg::DATA_BITS-1:0] dq_out,
  output logic                                dq_oe_lo,
  output logic                                dq_oe_hi,
  output logic      [sdram_pkg::NUM_BANKS-1:0] bank_open,
  output logic                                write_ready,
  output logic                                write_pending,
  output logic                                refresh_busy,
  output logic      [sdram_pkg::ROW_BITS-1:0]  refresh_row
);
  import sdram_pkg::*;

  typedef enum logic [1:0] {BURST_IDLE, BURST_READ, BURST_WRITE} burst_e;

  logic [BANK_BITS-1:0]     bank_sel;
  logic [3:0]               cmd;
  logic                     is_mrs, is_ref, is_pre, is_act;
  logic                     is_read, is_write, is_bst;
  logic [ADDR_BITS-1:0]     mode_reg;
  logic [NUM_BANKS-1:0]     bank_open_reg;
  logic [ROW_BITS-1:0]      row_reg [NUM_BANKS];
  burst_e                   burst_state_reg;
  logic [BANK_BITS-1:0]     burst_bank_reg;
  logic [COL_BITS-1:0]      burst_start_reg;
  logic [COL_BITS-1:0]      burst_idx_reg;
  logic [COL_BITS-1:0]      burst_mask_reg;
  logic                     burst_page_reg;
  logic                     burst_auto_pre_reg;
  logic [COL_BITS-1:0]      len_mask;
  logic                     page_mode;
  logic                     write_single;
  logic                     new_rw;
  logic                     stop_burst;
  logic                     beat_go;
  logic                     beat_write;
  logic                     beat_last;
  logic                     beat_page;
  logic                     beat_auto_pre;
  logic [BANK_BITS-1:0]     beat_bank;
  logic [COL_BITS-1:0]      beat_start;
  logic [COL_BITS-1:0]      beat_idx;
  logic [COL_BITS-1:0]      beat_mask;
  logic [COL_BITS-1:0]      beat_sum;
  logic [COL_BITS-1:0]      beat_col;
  logic [MEM_ADDR_BITS-1:0] beat_addr;
  logic                     rd_beat;
  logic [DATA_BITS-1:0]     mem [2**MEM_ADDR_BITS];
  logic [DATA_BITS-1:0]     mem_q_reg;
  logic [DATA_BITS-1:0]     q1_reg, q2_reg;
  logic [2:0]               rd_vld_reg;
  logic [1:0]               mask_reg;
  logic                     out_vld_reg;
  logic [DATA_BITS-1:0]     dq_out_reg;
  logic                     dq_oe_lo_reg, dq_oe_hi_reg;
  logic                     write_ready_reg, write_pending_reg;
  logic                     refresh_busy_reg;
  logic [1:0]               refresh_cnt_reg;
  logic [ROW_BITS-1:0]      refresh_row_reg;
  logic                     fifo_in_ready, fifo_out_valid, drain;
  logic [WFIFO_WIDTH-1:0]   fifo_in_data, fifo_out_data;
  logic [MEM_ADDR_BITS-1:0] drain_addr;

  // every decode is gated by clk_en: a low enable is no edge at all
  assign bank_sel = {bank_select_bit1, bank_select_bit0};
  assign cmd      = {chip_select_n, row_strobe_n, col_strobe_n,
                     write_enable_n};
  assign is_mrs   = clk_en && cmd == CMD_MRS;
  assign is_ref   = clk_en && cmd == CMD_REF;
  assign is_pre   = clk_en && cmd == CMD_PRE;
  assign is_act   = clk_en && cmd == CMD_ACT;
  assign is_read  = clk_en && cmd == CMD_READ;
  assign is_write = clk_en && cmd == CMD_WRITE;
  assign is_bst   = clk_en && cmd == CMD_BST;

  assign page_mode    = mode_reg[MODE_BL_LSB +: 3] == BL_PAGE;
  assign write_single = mode_reg[MODE_WB_BIT];

  always_comb
  begin
    case (mode_reg[MODE_BL_LSB +: 3])
      BL_1:    len_mask = 8'h00;
      BL_2:    len_mask = 8'h01;
      BL_4:    len_mask = 8'h03;
      BL_8:    len_mask = 8'h07;
      default: len_mask = 8'hFF;
    endcase
  end

  // access to a closed bank is dropped; controller must activate first
  assign new_rw = (is_read || is_write) && bank_open_reg[bank_sel];
  assign stop_burst = is_bst || (is_pre && (addr[AUTO_PRE_BIT]
                      || bank_sel == burst_bank_reg));

  always_comb
  begin
    case (burst_state_reg)
      BURST_WRITE: beat_write = 1'b1;
      default:     beat_write = 1'b0;
    endcase
    if (new_rw)
      beat_write = is_write;
  end

  assign beat_mask = new_rw ? ((is_write && write_single) ? 8'h00
                     : len_mask) : burst_mask_reg;
  assign beat_page = new_rw ? (page_mode && !(is_write && write_single))
                     : burst_page_reg;
  assign beat_start = new_rw ? addr[COL_BITS-1:0]
                      : burst_start_reg;
  assign beat_idx  = new_rw ? 8'h00 : burst_idx_reg;
  assign beat_bank = new_rw ? bank_sel : burst_bank_reg;
  assign beat_auto_pre = new_rw ? addr[AUTO_PRE_BIT]
                         : burst_auto_pre_reg;
  assign beat_go = new_rw || (clk_en && !stop_burst
                   && burst_state_reg != BURST_IDLE);
  assign beat_last = !beat_page && beat_idx == beat_mask;
  assign beat_sum  = COL_BITS'(beat_start + beat_idx);
  // wrap stays inside the burst-aligned block, as in a real device
  assign beat_col  = mode_reg[MODE_SEQ_BIT]
    ? (beat_start & ~beat_mask) | ((beat_start ^ beat_idx) & beat_mask)
    : (beat_start & ~beat_mask) | (beat_sum & beat_mask);
  assign beat_addr = {beat_bank, row_reg[beat_bank], beat_col};
  assign rd_beat   = beat_go && !beat_write;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      mode_reg <= MODE_RESET;
    else if (is_mrs && bank_open_reg == '0)
      mode_reg <= addr;
  end

  for (genvar b = 0; b < NUM_BANKS; b++)
  begin : g_bank
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        bank_open_reg[b] <= 1'b0;
        row_reg[b]       <= '0;
      end
      else if (is_act && bank_sel == BANK_BITS'(b))
      begin
        bank_open_reg[b] <= 1'b1;
        row_reg[b]       <= addr;
      end
      else if (is_pre && (addr[AUTO_PRE_BIT] || bank_sel == BANK_BITS'(b)))
        bank_open_reg[b] <= 1'b0;
      else if (beat_go && beat_last && beat_auto_pre
               && beat_bank == BANK_BITS'(b))
        bank_open_reg[b] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      burst_state_reg    <= BURST_IDLE;
      burst_bank_reg     <= '0;
      burst_start_reg    <= '0;
      burst_idx_reg      <= '0;
      burst_mask_reg     <= '0;
      burst_page_reg     <= 1'b0;
      burst_auto_pre_reg <= 1'b0;
    end
    else if (new_rw)
    begin
      burst_state_reg    <= beat_last ? BURST_IDLE
                            : (is_write ? BURST_WRITE : BURST_READ);
      burst_bank_reg     <= bank_sel;
      burst_start_reg    <= beat_start;
      burst_idx_reg      <= 8'h01;
      burst_mask_reg     <= beat_mask;
      burst_page_reg     <= beat_page;
      burst_auto_pre_reg <= beat_auto_pre;
    end
    else if (clk_en && stop_burst)
      burst_state_reg <= BURST_IDLE;
    else if (beat_go)
    begin
      if (beat_last)
        burst_state_reg <= BURST_IDLE;
      burst_idx_reg <= burst_idx_reg + 1'b1;
    end
  end

  // write beats queue; the array drains them when the read port is free
  assign fifo_in_data = {beat_addr, dq_in, ~upper_byte_mask,
                         ~lower_byte_mask};
  assign drain = fifo_out_valid && clk_en && !rd_beat && !refresh_busy_reg;
  assign drain_addr = fifo_out_data[WFIFO_WIDTH-1 -: MEM_ADDR_BITS];

  sync_fifo
  #(
    .WIDTH (WFIFO_WIDTH),
    .DEPTH (WFIFO_DEPTH)
  )
  u_wfifo
  (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .in_valid  (beat_go && beat_write),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (drain),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge sys_clk)
  begin
    if (rd_beat)
      mem_q_reg <= mem[beat_addr];
    if (drain && fifo_out_data[0])
      mem[drain_addr][7:0] <= fifo_out_data[9:2];
    if (drain && fifo_out_data[1])
      mem[drain_addr][15:8] <= fifo_out_data[17:10];
  end

  // read pipe: array register, then one or two stages before the pins
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_vld_reg <= '0;
      q1_reg     <= '0;
      q2_reg     <= '0;
      mask_reg   <= 2'h3;
    end
    else if (clk_en)
    begin
      rd_vld_reg <= {rd_vld_reg[1:0], rd_beat};
      q1_reg     <= mem_q_reg;
      q2_reg     <= q1_reg;
      mask_reg   <= {upper_byte_mask, lower_byte_mask};
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_vld_reg  <= 1'b0;
      dq_out_reg   <= '0;
      dq_oe_lo_reg <= 1'b0;
      dq_oe_hi_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (mode_reg[MODE_CL_LSB +: 3] == CL_3)
      begin
        out_vld_reg <= rd_vld_reg[2];
        dq_out_reg  <= q2_reg;
      end
      else
      begin
        out_vld_reg <= rd_vld_reg[1];
        dq_out_reg  <= q1_reg;
      end
      dq_oe_lo_reg <= (mode_reg[MODE_CL_LSB +: 3] == CL_3 ? rd_vld_reg[2]
                       : rd_vld_reg[1]) && !mask_reg[0];
      dq_oe_hi_reg <= (mode_reg[MODE_CL_LSB +: 3] == CL_3 ? rd_vld_reg[2]
                       : rd_vld_reg[1]) && !mask_reg[1];
    end
  end

  // refresh needs all rows closed; queued writes are held off the array meanwhile, reads are not
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      refresh_busy_reg <= 1'b0;
      refresh_cnt_reg  <= '0;
      refresh_row_reg  <= '0;
    end
    else if (is_ref && bank_open_reg == '0 && !refresh_busy_reg)
    begin
      refresh_busy_reg <= 1'b1;
      refresh_cnt_reg  <= 2'(REFRESH_CYCLES - 1);
      refresh_row_reg  <= refresh_row_reg + 1'b1;
    end
    else if (clk_en && refresh_busy_reg)
    begin
      if (refresh_cnt_reg == '0)
        refresh_busy_reg <= 1'b0;
      else
        refresh_cnt_reg <= refresh_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      write_ready_reg   <= 1'b1;
      write_pending_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      write_ready_reg   <= fifo_in_ready;
      write_pending_reg <= fifo_out_valid;
    end
  end

  assign dq_out        = dq_out_reg;
  assign dq_oe_lo      = dq_oe_lo_reg;
  assign dq_oe_hi      = dq_oe_hi_reg;
  assign bank_open     = bank_open_reg;
  assign write_ready   = write_ready_reg;
  assign write_pending = write_pending_reg;
  assign refresh_busy  = refresh_busy_reg;
  assign refresh_row   = refresh_row_reg;

  a_act_opens_bank: assert property (@(posedge sys_clk)
    disable iff (!reset_n) is_act |=> bank_open_reg[$past(bank_sel)])
    else $error("activation did not open the bank");
  a_pre_all_banks: assert property (@(posedge sys_clk)
    disable iff (!reset_n) is_pre && addr[AUTO_PRE_BIT]
    |=> bank_open_reg == '0)
    else $error("precharge all left a bank open");
  a_pre_one_bank: assert property (@(posedge sys_clk)
    disable iff (!reset_n) is_pre && !addr[AUTO_PRE_BIT]
    |=> !bank_open_reg[$past(bank_sel)])
    else $error("single precharge missed its bank");
  a_mode_load: assert property (@(posedge sys_clk)
    disable iff (!reset_n) is_mrs && bank_open_reg == '0
    |=> mode_reg == $past(addr))
    else $error("mode load not stored");
  a_deselect_holds: assert property (@(posedge sys_clk)
    disable iff (!reset_n) clk_en && chip_select_n
    |=> $stable(mode_reg) && !$rose(bank_open_reg[0]))
    else $error("deselected command took effect");
  a_freeze_state: assert property (@(posedge sys_clk)
    disable iff (!reset_n) !clk_en |=> $stable(burst_state_reg)
    && $stable(bank_open_reg) && $stable(rd_vld_reg)
    && $stable(dq_out_reg))
    else $error("state moved with clock enable low");
  a_bst_ends_burst: assert property (@(posedge sys_clk)
    disable iff (!reset_n) is_bst |=> burst_state_reg == BURST_IDLE)
    else $error("burst stop did not end the burst");
  a_read_cl_two: assert property (@(posedge sys_clk)
    disable iff (!reset_n) rd_beat && mode_reg[MODE_CL_LSB +: 3] == CL_2
    ##1 clk_en[*3] |-> out_vld_reg)
    else $error("read data late for latency two");
  a_read_cl_three: assert property (@(posedge sys_clk)
    disable iff (!reset_n) rd_beat && mode_reg[MODE_CL_LSB +: 3] == CL_3
    ##1 clk_en[*4] |-> out_vld_reg)
    else $error("read data late for latency three");
  a_single_write: assert property (@(posedge sys_clk)
    disable iff (!reset_n) new_rw && is_write && write_single
    |=> burst_state_reg == BURST_IDLE)
    else $error("single write mode kept bursting");
  a_read_mask_hi: assert property (@(posedge sys_clk)
    disable iff (!reset_n) clk_en && upper_byte_mask ##1 clk_en
    |=> !dq_oe_hi_reg)
    else $error("masked upper byte was driven");
  a_auto_precharge: assert property (@(posedge sys_clk)
    disable iff (!reset_n) beat_go && beat_last && beat_auto_pre && !is_act
    |=> !bank_open_reg[$past(beat_bank)])
    else $error("auto precharge left the row open");
endmodule : sdram_device

// ### include/sdram_pkg.sv
// constants for the four-bank synchronous dram device model
package sdram_pkg;
  localparam int BANK_BITS     = 2;
  localparam int NUM_BANKS     = 4;
  localparam int ROW_BITS      = 12;
  localparam int COL_BITS      = 8;
  localparam int ADDR_BITS     = 12;
  localparam int DATA_BITS     = 16;
  localparam int MEM_ADDR_BITS = BANK_BITS + ROW_BITS + COL_BITS;

  // {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n}
  localparam logic [3:0] CMD_MRS   = 4'h0;
  localparam logic [3:0] CMD_REF   = 4'h1;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ  = 4'h5;
  localparam logic [3:0] CMD_BST   = 4'h6;

  localparam int AUTO_PRE_BIT = 10;

  // operating configuration fields
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_SEQ_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_WB_BIT = 9;
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] CL_2    = 3'h2;
  localparam logic [2:0] CL_3    = 3'h3;
  localparam logic [11:0] MODE_RESET = 12'h020;

  localparam int CLK_PERIOD_NS   = 40;
  localparam int REFRESH_TIME_NS = 70;
  localparam int REFRESH_CYCLES  =
    (REFRESH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int WFIFO_DEPTH = 16;
  localparam int WFIFO_WIDTH = MEM_ADDR_BITS + DATA_BITS + 2;
endpackage : sdram_pkg

// ### rtl/sync_fifo.sv
// single-clock fifo buffering accepted write beats
`timescale 1ns/10ps
module sync_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  // depth must be a power of two: pointers wrap by overflow
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = count_reg != FULL_COUNT;
  assign out_valid = count_reg != '0;
  assign out_data  = store[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk)
  begin
    if (clk_en && push)
      store[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else if (clk_en)
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule : sync_fifo

// ### bench/sdram_host_model.sv
// host controller model driving command, address and write data lines
`timescale 1ns/10ps
module sdram_host_model
(
  input  wire logic                             sys_clk,
  output logic                                  clk_en,
  output logic                                  chip_select_n,
  output logic                                  row_strobe_n,
  output logic                                  col_strobe_n,
  output logic                                  write_enable_n,
  output logic                                  bank_select_bit0,
  output logic                                  bank_select_bit1,
  output logic      [sdram_pkg::ADDR_BITS-1:0]  addr,
  output logic                                  lower_byte_mask,
  output logic                                  upper_byte_mask,
  output logic      [sdram_pkg::DATA_BITS-1:0]  dq_in
);
  import sdram_pkg::*;
  initial
  begin
    clk_en = 1'b1;
    {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = 4'h7;
    {bank_select_bit1, bank_select_bit0} = 2'h0;
    addr = 12'h000;
    {upper_byte_mask, lower_byte_mask} = 2'h0;
    dq_in = 16'hA5A5;
  end
  // lines change at the falling edge and hold across the taking edge
  task automatic send(input logic [3:0] cmd, input logic [1:0] b,
                      input logic [11:0] a, input logic [15:0] d,
                      input logic [1:0] m);
    @(negedge sys_clk);
    {chip_select_n, row_strobe_n, col_strobe_n,
     write_enable_n} = cmd;
    {bank_select_bit1, bank_select_bit0} = b;
    addr = a;
    {upper_byte_mask, lower_byte_mask} = m;
    // undriven data bus never repeats its last word
    dq_in = (cmd == CMD_WRITE) ? d : ~dq_in;
    @(posedge sys_clk);
  endtask : send
  // idle commands carry random bank and address: the device must ignore them
  task automatic nop(input int n, input logic [1:0] m = 2'h0);
    repeat (n) send(4'h7, 2'($urandom), 12'($urandom), 16'h0000, m);
  endtask : nop
  task automatic set_cke(input logic v);
    @(negedge sys_clk);
    clk_en = v;
  endtask : set_cke
endmodule : sdram_host_model

// ### bench/sdram_command_bank_burst_bench.sv
// self-checking bench for the sdram device core against a queue model
`timescale 1ns/10ps
module sdram_command_bank_burst_bench;
  import sdram_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n;
  logic clk_en, cs_n, ras_n, cas_n, we_n, b0, b1, lm, um;
  logic [11:0] addr;
  logic [15:0] dq_in, dq_out;
  logic dq_oe_lo, dq_oe_hi, write_ready, write_pending, refresh_busy;
  logic [3:0] bank_open;
  logic [11:0] refresh_row;
  logic [15:0] mem [int];
  logic [15:0] exp_q [$];
  logic [11:0] row_q [4];
  int n_mismatch = 0;
  int checks_done = 0;
  int s;

  always #20 sys_clk = ~sys_clk;

  sdram_host_model sdram_host_model_inst (.sys_clk(sys_clk),
    .clk_en(clk_en), .chip_select_n(cs_n), .row_strobe_n(ras_n),
    .col_strobe_n(cas_n), .write_enable_n(we_n), .bank_select_bit0(b0),
    .bank_select_bit1(b1), .addr(addr), .lower_byte_mask(lm),
    .upper_byte_mask(um), .dq_in(dq_in));
  sdram_device sdram_device_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .clk_en(clk_en), .chip_select_n(cs_n), .row_strobe_n(ras_n),
    .col_strobe_n(cas_n), .write_enable_n(we_n), .bank_select_bit0(b0),
    .bank_select_bit1(b1), .addr(addr), .lower_byte_mask(lm),
    .upper_byte_mask(um), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_lo(dq_oe_lo), .dq_oe_hi(dq_oe_hi), .bank_open(bank_open),
    .write_ready(write_ready), .write_pending(write_pending),
    .refresh_busy(refresh_busy), .refresh_row(refresh_row));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic act(input logic [1:0] b, input logic [11:0] r);
    row_q[b] = r;
    sdram_host_model_inst.send(CMD_ACT, b, r, 16'h0000, 2'h0);
  endtask : act

  task automatic wr(input logic [1:0] b, input logic [7:0] c,
                    input logic [15:0] d, input logic [1:0] m);
    int k;
    k = {b, row_q[b], c};
    sdram_host_model_inst.send(CMD_WRITE, b, {4'h0, c}, d, m);
    if (!m[0]) mem[k][7:0] = d[7:0];
    if (!m[1]) mem[k][15:8] = d[15:8];
  endtask : wr

  // reads miss words still queued, so let the write queue empty first
  task automatic drain;
    int i;
    sdram_host_model_inst.nop(2);
    #1;
    for (i = 0; i < 20 && write_pending !== 1'b0; i++)
    begin
      sdram_host_model_inst.nop(1);
      #1;
    end
    if (i >= 20)
    begin
      n_mismatch++;
      give_verdict();
    end
  endtask : drain

  // checks queued beats, one per cycle after pre idle cycles, then idle bus;
  // masks m ride on every idle command, so the enables follow their inverse
  task automatic beats(input int pre, input logic [1:0] m);
    sdram_host_model_inst.nop(pre, m);
    while (exp_q.size() > 0)
    begin
      sdram_host_model_inst.nop(1, m);
      #1;
      chk(dq_out, exp_q.pop_front());
      chk({14'h0000, dq_oe_hi, dq_oe_lo}, {14'h0000, ~m});
    end
    sdram_host_model_inst.nop(1, m);
    #1;
    chk({14'h0000, dq_oe_hi, dq_oe_lo}, 16'h0000);
  endtask : beats

  initial
  begin
    reset_n = 1'b0;
    void'($urandom(19));
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    #1;
    chk({bank_open, write_ready, write_pending, refresh_busy, dq_oe_hi,
         dq_oe_lo, 7'h00}, 16'h0800);
    // deselect with random strobes, then an activation under a low enable;
    // a command line left up while the enable returns would be taken
    sdram_host_model_inst.send({1'b1, 3'($urandom)}, 2'($urandom),
                               12'($urandom), 16'h0000, 2'h0);
    sdram_host_model_inst.set_cke(1'b0);
    sdram_host_model_inst.send(CMD_ACT, 2'h0, 12'h001, 16'h0000, 2'h0);
    sdram_host_model_inst.nop(1);
    sdram_host_model_inst.set_cke(1'b1);
    sdram_host_model_inst.nop(1);
    #1;
    chk({12'h000, bank_open}, 16'h0000);
    $display("end of test ignore");
    sdram_host_model_inst.send(CMD_REF, 2'h0, 12'h000, 16'h0000,
                               2'h0);
    #1;
    chk({15'h0000, refresh_busy}, 16'h0001);
    sdram_host_model_inst.nop(4);
    #1;
    chk({refresh_busy, 3'h0, refresh_row}, 16'h0001);
    $display("end of test refresh");
    act(2'h1, 12'($urandom));
    sdram_host_model_inst.nop(1);
    #1;
    chk({12'h000, bank_open}, 16'h0002);
    wr(2'h1, 8'h7F, 16'($urandom), 2'h0);
    wr(2'h1, 8'h7F, 16'($urandom), 2'($urandom));
    drain();
    sdram_host_model_inst.send(CMD_READ, 2'h1, 12'h07F, 16'h0, 2'h0);
    exp_q.push_back(mem[{2'h1, row_q[1], 8'h7F}]);
    beats(1, 2'($urandom));
    $display("end of test write read");
    act(2'h3, 12'hFFF);
    sdram_host_model_inst.send(CMD_PRE, 2'h1, 12'h000, 16'h0, 2'h0);
    sdram_host_model_inst.nop(1);
    #1;
    chk({12'h000, bank_open}, 16'h0008);
    sdram_host_model_inst.send(CMD_PRE, 2'h0, 12'h400, 16'h0, 2'h0);
    sdram_host_model_inst.nop(1);
    #1;
    chk({12'h000, bank_open}, 16'h0000);
    $display("end of test banks");
    // length 4, interleaved, latency 3, single-location writes
    sdram_host_model_inst.send(CMD_MRS, 2'h0, 12'h23A, 16'h0,
                               2'h0);
    act(2'h2, 12'($urandom));
    for (int i = 0; i < 4; i++)
      wr(2'h2, 8'(8'h10 + i), 16'($urandom), 2'h0);
    drain();
    s = $urandom_range(3);
    sdram_host_model_inst.send(CMD_READ, 2'h2, 12'(12'h410 + s), 16'h0,
                               2'h0);
    for (int i = 0; i < 4; i++)
      exp_q.push_back(mem[{2'h2, row_q[2], 8'(8'h10 + (s ^ i))}]);
    beats(2, 2'h2);
    chk({12'h000, bank_open}, 16'h0000);
    $display("end of test burst");
    act(2'h2, row_q[2]);
    sdram_host_model_inst.send(CMD_READ, 2'h2, 12'h012, 16'h0, 2'h0);
    sdram_host_model_inst.send(CMD_READ, 2'h2, 12'h011, 16'h0, 2'h0);
    sdram_host_model_inst.send(CMD_BST, 2'h2, 12'h000, 16'h0, 2'h0);
    exp_q.push_back(mem[{2'h2, row_q[2], 8'h12}]);
    exp_q.push_back(mem[{2'h2, row_q[2], 8'h11}]);
    beats(0, 2'h0);
    $display("end of test stop");
    give_verdict();
  end
endmodule : sdram_command_bank_burst_bench
